// ### logic/sfra_top.sv
// Safety fault classification, stop reaction and fail-safe acknowledgement
//
// Behaviour
// - Immediate cutoff removes torque at once, no braking phase.
// - Ramped stop brakes on fast-stop ramp to standstill, then cuts off.
// - Ramped stop under torque control forces speed control.
// - Ramped stop deceleration is supervised like safe stop one.
// - Leaving the ramp aborts braking and cuts torque off.
// - Internal events react with cutoff or ramped stop.
// - Cross-check fault as cause gives immediate cutoff.
// - Cross-check alarm with no safety function active is dropped.
// - Cross-check alarm with safe torque off active gives cutoff.
// - Cross-check alarm with another safety function active and safe torque off inactive gives ramped stop.
// - Cross-check hardware or firmware fault is an internal event.
// - Speed limit violation is an internal event.
// - Internal events clear only by fail-safe acknowledgement.
// - Discrepant fail-safe input is read as zero.
// - Discrepant input stays safe until fail-safe ack or power-on reset.
// - General faults clear without fail-safe acknowledgement.
// - Power-on reset acknowledges all safety faults.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
module sfra_top
  import sfra_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Fail-safe input pins
  input wire logic [SFRA_NFDI-1:0] fdi_pin_i,
  // Fieldbus control word and safety function state
  input wire logic [FB_W-1:0] fb_ctrl_i,
  input wire logic sto_active_i,
  input wire logic other_sf_active_i,
  input wire logic [SPD_W-1:0] speed_i,
  // Fault events, one-cycle pulses
  input wire logic xcheck_fault_i,
  input wire logic xcheck_alarm_i,
  input wire logic speed_viol_i,
  input wire logic param_fault_i,
  input wire logic accept_test_i,
  input wire logic [SFRA_NFDI-1:0] disc_i,
  // Reactions and status
  output logic torque_off_o,
  output logic ramp_active_o,
  output logic speed_mode_o,
  output logic [SPD_W-1:0] speed_setpoint_o,
  output logic internal_event_o,
  output logic general_fault_o,
  output logic [SFRA_NFDI-1:0] fdi_safe_o
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [SFRA_NFDI-1:0] sync1;
  logic [SFRA_NFDI-1:0] sync2;
  logic [SFRA_NFDI-1:0] disc_hold;
  logic [SFRA_NFDI-1:0] fdi_eval;
  logic [SEQ_W-1:0] seq_lvl;
  logic [SEQ_W-1:0] seq_hit;
  logic fs_ack;
  logic ack_armed;
  logic full_ack;
  logic int_event;
  logic gen_fault;
  logic gen_set;
  sfra_stop_e stop_state;
  sfra_stop_e next_stop;
  logic cut_req;
  logic ramp_req;
  logic ramp_start;
  logic ramp_act;
  logic ramp_sst;
  logic ramp_viol;
  logic [SPD_W-1:0] ramp_sp;
  logic [1:0] ctrl;
  logic [SPD_W-1:0] ramp_div;
  logic [31:0] mon;
  logic [31:0] wmask;
  logic wr_en;
  logic std_ack_wr;
  logic gen_clr_wr;
  logic [31:0] rd_val;
  logic rd_hit;

  // ****************************************
  // Pin synchronisers and discrepancy hold
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < SFRA_NFDI; g++) begin : g_fdi
      // Two stages before any logic sees the pin
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= fdi_pin_i[g];
          sync2[g] <= sync1[g];
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          disc_hold[g] <= 1'b0;
        end else if (disc_i[g]) begin
          disc_hold[g] <= 1'b1; // New discrepancy beats a clear
        end else if (full_ack) begin
          disc_hold[g] <= 1'b0;
        end
      end
      assign fdi_eval[g] = sync2[g] & ~disc_hold[g];
    end
  endgenerate

  // Evaluated fail-safe inputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) fdi_safe_o <= '0;
    else fdi_safe_o <= fdi_eval;
  end

  // ****************************************
  // Fail-safe acknowledgement
  // ****************************************
  // acknowledge pulse lanes, a discrepant select lane held idle
  assign seq_lvl = {fb_ctrl_i[FB_STO_B], fb_ctrl_i[FB_SS1_B],
                    sync2[FDI_STO] | disc_hold[FDI_STO], fb_ctrl_i[FB_ACK_B], fdi_eval[FDI_ACK]};

  sfra_seq_det u_seq (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .level_i(seq_lvl),
    .seq_o(seq_hit)
  );

  assign fs_ack = |seq_hit;
  assign full_ack = std_ack_wr & (ack_armed | fs_ack);

  // Armed by a fail-safe sequence, consumed by the standard ack
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) ack_armed <= 1'b0;
    else if (std_ack_wr) ack_armed <= 1'b0; // A same-cycle sequence is used up here
    else if (fs_ack) ack_armed <= 1'b1;
  end

  // ****************************************
  // Fault classification
  // ****************************************
  // general faults, set beats clear
  assign gen_set = param_fault_i | accept_test_i;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) gen_fault <= 1'b0;
    else if (gen_set) gen_fault <= 1'b1;
    else if (gen_clr_wr) gen_fault <= 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_event <= 1'b0;
    end else if (xcheck_fault_i || speed_viol_i ||
                 (xcheck_alarm_i && (sto_active_i || other_sf_active_i))) begin
      int_event <= 1'b1;
    end else if (full_ack) begin
      int_event <= 1'b0;
    end
  end

  assign cut_req = xcheck_fault_i | (xcheck_alarm_i & sto_active_i) |
                   (speed_viol_i & ~ctrl[CTRL_REACT_B]);
  assign ramp_req = (xcheck_alarm_i & ~sto_active_i & other_sf_active_i) |
                    (speed_viol_i & ctrl[CTRL_REACT_B]);

  // ****************************************
  // Stop reaction state machine
  // ****************************************
  always_comb begin
    next_stop = stop_state;
    ramp_start = 1'b0;
    unique case (stop_state)
      SFRA_RUN: begin
        if (cut_req) begin
          next_stop = SFRA_CUT;
        end else if (ramp_req) begin
          next_stop = SFRA_RAMP;
          ramp_start = 1'b1;
        end
      end
      SFRA_RAMP: begin
        if (cut_req || ramp_viol || ramp_sst) next_stop = SFRA_CUT;
      end
      SFRA_CUT: begin
        if (full_ack && !cut_req && !ramp_req) next_stop = SFRA_RUN;
      end
      default: next_stop = SFRA_CUT;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) stop_state <= SFRA_RUN;
    else stop_state <= next_stop;
  end

  // Reaction outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      torque_off_o <= 1'b0;
      ramp_active_o <= 1'b0;
      speed_mode_o <= 1'b0;
      internal_event_o <= 1'b0;
      general_fault_o <= 1'b0;
      speed_setpoint_o <= '0;
    end else begin
      torque_off_o <= (next_stop == SFRA_CUT);
      ramp_active_o <= (next_stop == SFRA_RAMP);
      speed_mode_o <= (next_stop == SFRA_RAMP) & ctrl[CTRL_TRQ_B];
      internal_event_o <= int_event;
      general_fault_o <= gen_fault;
      speed_setpoint_o <= ramp_sp;
    end
  end

  sfra_ramp u_ramp (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(ramp_start),
    .abort_i(cut_req),
    .speed_i(speed_i),
    .ramp_div_i(ramp_div),
    .tol_i(mon[SPD_W-1:0]),
    .sst_i(mon[MON_SST_B +: SPD_W]),
    .active_o(ramp_act),
    .setpoint_o(ramp_sp),
    .standstill_o(ramp_sst),
    .viol_o(ramp_viol)
  );

  // ****************************************
  // APB register file
  // ****************************************
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign std_ack_wr = wr_en & (paddr_i == OFF_ACK) & pstrb_i[0] & pwdata_i[ACK_STD_B];
  assign gen_clr_wr = wr_en & (paddr_i == OFF_ACK) & pstrb_i[0] & pwdata_i[ACK_GEN_B];

  // Read mux and address decode
  always_comb begin
    rd_val = ZERO32;
    rd_hit = 1'b1;
    unique case (paddr_i)
      OFF_CTRL: rd_val[CTRL_TRQ_B:CTRL_REACT_B] = ctrl;
      OFF_ACK: rd_val = ZERO32;
      OFF_STAT: begin
        rd_val[STAT_GEN_B] = gen_fault;
        rd_val[STAT_INT_B] = int_event;
        rd_val[STAT_STOP_B +: $bits(sfra_stop_e)] = stop_state;
        rd_val[STAT_DISC_B +: SFRA_NFDI] = disc_hold;
        rd_val[STAT_ARM_B] = ack_armed;
        rd_val[STAT_SPD_B] = ramp_act & ctrl[CTRL_TRQ_B];
      end
      OFF_RAMP: rd_val[SPD_W-1:0] = ramp_div;
      OFF_MON: rd_val = mon;
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer one cycle after setup
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= ZERO32;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i & ~pready_o;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_val : ZERO32;
      pslverr_o <= psel_i & ~penable_i & ~rd_hit;
    end
  end

  // Writable configuration
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      ramp_div <= RAMP_RST;
      mon <= MON_RST;
    end else if (wr_en) begin
      if (paddr_i == OFF_CTRL && pstrb_i[0]) ctrl <= pwdata_i[CTRL_TRQ_B:CTRL_REACT_B];
      if (paddr_i == OFF_RAMP) begin
        ramp_div <= (ramp_div & ~wmask[SPD_W-1:0]) | (pwdata_i[SPD_W-1:0] & wmask[SPD_W-1:0]);
      end
      if (paddr_i == OFF_MON) mon <= (mon & ~wmask) | (pwdata_i & wmask);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  cut_fast_a: assert property (xcheck_fault_i |=> torque_off_o)
    else $error("cross-check fault did not cut torque");
  ramp_end_a: assert property (
    (stop_state == SFRA_RAMP && ramp_sst) |=> (stop_state == SFRA_CUT) && torque_off_o)
    else $error("standstill did not end in cutoff");
  speed_mode_a: assert property (
    (stop_state == SFRA_RUN && ramp_start && ctrl[CTRL_TRQ_B]) |=> speed_mode_o)
    else $error("ramp under torque control kept torque mode");
  ramp_abort_a: assert property (
    (stop_state == SFRA_RAMP && ramp_viol) |=> torque_off_o && !ramp_active_o)
    else $error("ramp deviation did not abort braking");
  alarm_idle_a: assert property (
    (stop_state == SFRA_RUN && xcheck_alarm_i && !sto_active_i && !other_sf_active_i &&
     !xcheck_fault_i && !speed_viol_i) |=> stop_state == SFRA_RUN && !$changed(int_event))
    else $error("idle cross-check alarm disturbed the motor");
  alarm_sto_a: assert property (
    (xcheck_alarm_i && sto_active_i) |=> torque_off_o ##1 torque_off_o)
    else $error("alarm under torque off did not cut torque");
  alarm_ramp_a: assert property (
    (stop_state == SFRA_RUN && xcheck_alarm_i && !sto_active_i && other_sf_active_i &&
     !xcheck_fault_i && !speed_viol_i) |=> ramp_active_o && !torque_off_o)
    else $error("alarm under other function did not ramp");
  event_hold_a: assert property (
    (int_event && !full_ack) |=> int_event)
    else $error("internal event cleared without fail-safe ack");
  disc_zero_a: assert property (
    disc_i[FDI_STO] |=> ##1 !fdi_safe_o[FDI_STO])
    else $error("discrepant input not forced to zero");
  gen_clear_a: assert property (
    (gen_clr_wr && !gen_set) |=> ##1 !general_fault_o)
    else $error("general fault not cleared by software");

  ramp_done_c: cover property (stop_state == SFRA_RAMP && ramp_sst);
  full_ack_c: cover property (int_event ##[1:200] full_ack);
  disc_ack_c: cover property (disc_hold[FDI_STO] && full_ack);
endmodule
`default_nettype wire

// ### logic/sfra_pkg.sv
// Constants, field layout and state types of the safety fault reaction block
`default_nettype none
package sfra_pkg;
  // ****************************************
  // Fail-safe inputs and fieldbus control word
  // ****************************************
  localparam int SFRA_NFDI = 2;
  localparam int FDI_STO = 0;
  localparam int FDI_ACK = 1;
  localparam int FB_W = 8;
  localparam int FB_STO_B = 0;
  localparam int FB_SS1_B = 1;
  localparam int FB_ACK_B = 7;
  // Sequence detector lanes and their idle levels
  localparam int SEQ_W = 5;
  localparam logic [SEQ_W-1:0] SEQ_IDLE = 5'h1C;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_ACK = 8'h04;
  localparam logic [AW-1:0] OFF_STAT = 8'h08;
  localparam logic [AW-1:0] OFF_RAMP = 8'h0C;
  localparam logic [AW-1:0] OFF_MON = 8'h10;
  // Field positions
  localparam int CTRL_REACT_B = 0;
  localparam int CTRL_TRQ_B = 1;
  localparam int ACK_STD_B = 0;
  localparam int ACK_GEN_B = 1;
  localparam int STAT_GEN_B = 0;
  localparam int STAT_INT_B = 1;
  localparam int STAT_STOP_B = 2;
  localparam int STAT_DISC_B = 4;
  localparam int STAT_ARM_B = 6;
  localparam int STAT_SPD_B = 7;
  localparam int SPD_W = 16;
  localparam int MON_SST_B = 16;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [SPD_W-1:0] RAMP_RST = 16'h0064;
  localparam logic [31:0] MON_RST = 32'h0008_0010;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {
    SFRA_RUN = 2'b00,
    SFRA_RAMP = 2'b01,
    SFRA_CUT = 2'b10
  } sfra_stop_e;

  typedef enum logic [1:0] {
    SFRA_SEQ_WAIT = 2'b00,
    SFRA_SEQ_FIRST = 2'b01,
    SFRA_SEQ_MID = 2'b10
  } sfra_seq_e;
endpackage
`default_nettype wire

// ### logic/sfra_seq_det.sv
// Edge sequence detector for fail-safe acknowledgement pulses
`default_nettype none
module sfra_seq_det
  import sfra_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Sampled levels and detected sequences
  input wire logic [SEQ_W-1:0] level_i,
  output logic [SEQ_W-1:0] seq_o
);
  // ****************************************
  // One tracker per lane: idle, active, idle
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < SEQ_W; g++) begin : g_lane
      sfra_seq_e st;
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          st <= SFRA_SEQ_WAIT;
          seq_o[g] <= 1'b0;
        end else begin
          seq_o[g] <= 1'b0;
          unique case (st)
            SFRA_SEQ_WAIT: begin
              if (level_i[g] == SEQ_IDLE[g]) st <= SFRA_SEQ_FIRST;
            end
            SFRA_SEQ_FIRST: begin
              if (level_i[g] != SEQ_IDLE[g]) st <= SFRA_SEQ_MID;
            end
            SFRA_SEQ_MID: begin
              if (level_i[g] == SEQ_IDLE[g]) begin
                st <= SFRA_SEQ_FIRST; // Return to idle closes the pulse
                seq_o[g] <= 1'b1;
              end
            end
            default: st <= SFRA_SEQ_WAIT;
          endcase
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### logic/sfra_ramp.sv
// Monitored fast-stop ramp generator with standstill and deviation detection
`default_nettype none
module sfra_ramp
  import sfra_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [SPD_W-1:0] speed_i,
  input wire logic [SPD_W-1:0] ramp_div_i,
  input wire logic [SPD_W-1:0] tol_i,
  input wire logic [SPD_W-1:0] sst_i,
  // Status
  output logic active_o,
  output logic [SPD_W-1:0] setpoint_o,
  output logic standstill_o,
  output logic viol_o
);
  logic [SPD_W-1:0] div_cnt;
  logic [SPD_W:0] limit;

  // Allowed speed is the ramp setpoint plus tolerance
  assign limit = {1'b0, setpoint_o} + {1'b0, tol_i};

  // ****************************************
  // Ramp and supervision
  // ****************************************
  // fast-stop ramp
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      setpoint_o <= '0;
      div_cnt <= '0;
      standstill_o <= 1'b0;
      viol_o <= 1'b0;
    end else begin
      standstill_o <= 1'b0;
      viol_o <= 1'b0;
      if (start_i && !active_o) begin
        active_o <= 1'b1;
        setpoint_o <= speed_i;
        div_cnt <= ramp_div_i;
      end else if (active_o) begin
        if (abort_i) begin
          active_o <= 1'b0;
        end else if ({1'b0, speed_i} > limit) begin
          active_o <= 1'b0; // Motor left the ramp
          viol_o <= 1'b1;
        end else if (speed_i <= sst_i) begin
          active_o <= 1'b0;
          standstill_o <= 1'b1;
        end else if (div_cnt == '0) begin
          div_cnt <= ramp_div_i;
          if (setpoint_o != '0) setpoint_o <= setpoint_o - 1'b1;
        end else begin
          div_cnt <= div_cnt - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/sfra_ctrl_model.sv
// Safety controller model driving fail-safe pins and the fieldbus word
`default_nettype none
module sfra_ctrl_model
  import sfra_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Sequence request
  input wire logic go_i,
  input wire logic [2:0] lane_i,
  input wire logic [3:0] hold_i,
  // Driven lines
  output logic [SFRA_NFDI-1:0] fdi_pin_o,
  output logic [FB_W-1:0] fb_ctrl_o,
  output logic busy_o
);
  logic [1:0] ph;
  logic [3:0] cnt;
  logic act;
  // Phase walk: active level, then idle again, each held hold_i+1 cycles
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ph <= 2'h0;
      cnt <= 4'h0;
    end else if (ph == 2'h0) begin
      if (go_i) begin
        ph <= 2'h1;
        cnt <= hold_i;
      end
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : 2'h2;
      cnt <= hold_i;
    end
  end
  assign act = (ph == 2'h1);
  assign busy_o = (ph != 2'h0);
  always_comb begin
    fdi_pin_o = 2'h1;
    fb_ctrl_o = 8'h03;
    case (lane_i)
      3'h0: fdi_pin_o[FDI_ACK] = act;
      3'h1: fb_ctrl_o[FB_ACK_B] = act;
      3'h2: fdi_pin_o[FDI_STO] = !act;
      3'h3: fb_ctrl_o[FB_STO_B] = !act;
      default: fb_ctrl_o[FB_SS1_B] = !act;
    endcase
  end
endmodule
`default_nettype wire

// ### dv/safety_fault_reaction_ack_bench.sv
// Self-checking bench for the safety fault reaction block
`default_nettype none
module safety_fault_reaction_ack_bench
  import sfra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err, go, busy;
  logic sto_act, oth_act, torque_off, ramp_act, spd_mode, int_ev, gen_flt;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [SFRA_NFDI-1:0] fdi_pin, disc, fdi_safe;
  logic [FB_W-1:0] fb_ctrl;
  logic [SPD_W-1:0] speed, setp;
  logic [4:0] ev;
  logic [2:0] lane;
  logic [3:0] hold;
  int fails, comparisons, seed, n, i;
  sfra_top dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fdi_pin_i(fdi_pin),
    .fb_ctrl_i(fb_ctrl), .sto_active_i(sto_act), .other_sf_active_i(oth_act),
    .speed_i(speed), .xcheck_fault_i(ev[0]), .xcheck_alarm_i(ev[1]),
    .speed_viol_i(ev[2]), .param_fault_i(ev[3]), .accept_test_i(ev[4]), .disc_i(disc),
    .torque_off_o(torque_off), .ramp_active_o(ramp_act), .speed_mode_o(spd_mode),
    .speed_setpoint_o(setp), .internal_event_o(int_ev), .general_fault_o(gen_flt),
    .fdi_safe_o(fdi_safe));
  sfra_ctrl_model ctl_u (.sys_clk_i(sys_clk), .rst_i(rst), .go_i(go), .lane_i(lane),
    .hold_i(hold), .fdi_pin_o(fdi_pin), .fb_ctrl_o(fb_ctrl), .busy_o(busy));
  // ****************************************
  // Tasks and expectations
  // ****************************************
  task test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task hang(input string nm);
    $display("FAIL %s expected done seen timeout", nm);
    fails++;
    test_done();
  endtask
  // Stop reaction for a cross-check alarm: {ramp, cutoff}
  function automatic logic [1:0] xa_exp(input logic safe_torque_off, input logic oth);
    return {oth & !safe_torque_off, safe_torque_off};
  endfunction
  // APB transfer from the next edge; pready and data are taken at the ready edge
  task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      if (k++ > 20) hang("pready");
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  task fire(input int b);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    #1;
  endtask
  // Fail-safe pulse on one lane, then the standard acknowledge
  task fsack(input logic [2:0] l);
    int k;
    k = 0;
    @(posedge sys_clk);
    lane <= l;
    hold <= 4'h1 + 4'($random(seed) & 3);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1) begin
      if (k++ > 100) hang("sequence");
      @(posedge sys_clk);
      #1;
    end
    repeat (4) @(posedge sys_clk);
    apb(1'b1, OFF_ACK, 32'h0000_0001);
  endtask
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    hang("run");
  end
  initial begin
    seed = 57660;
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    {psel, penable, pwrite, go, sto_act, oth_act} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lane = 3'h0;
    hold = 4'h1;
    speed = 16'h0000;
    disc = 2'h0;
    ev = 5'h00;
    // Reset held for two edges at the start
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("outputs", 0, {torque_off, ramp_act, spd_mode, int_ev, gen_flt});
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk("ctrl", {30'h0, CTRL_RST}, rd);
    apb(1'b0, OFF_RAMP, 32'h0000_0000);
    chk("ramp", {16'h0, RAMP_RST}, rd);
    apb(1'b0, OFF_MON, 32'h0000_0000);
    chk("mon", MON_RST, rd);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk("unmapped", 1, err);
    for (i = 0; i < 5; i++) begin
      fire(0);
      chk("cut at once", 1, torque_off);
      @(posedge sys_clk);
      #1;
      chk("internal event", 1, int_ev);
      apb(1'b1, OFF_ACK, 32'h0000_0001);
      chk("plain ack", 1, torque_off);
      fsack(3'(i));
      chk("ack clears", 0, {torque_off, int_ev});
    end
    for (i = 0; i < 4; i++) begin
      do_reset;
      apb(1'b1, OFF_CTRL, 32'h0000_0002);
      @(posedge sys_clk);
      speed <= 16'h0100 + 16'($random(seed) & 255);
      sto_act <= i[0];
      oth_act <= i[1];
      fire(1);
      chk("alarm cut", 32'(xa_exp(i[0], i[1]) & 2'h1), torque_off);
      @(posedge sys_clk);
      #1;
      chk("alarm ramp", 32'(xa_exp(i[0], i[1]) >> 1), ramp_act);
      chk("speed mode", 32'(xa_exp(i[0], i[1]) >> 1), spd_mode);
      chk("alarm event", i[0] | i[1], int_ev);
    end
    for (i = 0; i < 3; i++) begin
      do_reset;
      {sto_act, oth_act} <= 2'h0;
      apb(1'b1, OFF_CTRL, (i == 0) ? 32'h0000_0000 : 32'h0000_0001);
      apb(1'b1, OFF_RAMP, 32'h0000_0000);
      @(posedge sys_clk);
      speed <= 16'h0040 + 16'($random(seed) & 63);
      fire(2);
      chk("viol cut", i == 0, torque_off);
      n = 0;
      // In the standstill run (i == 2) the motor follows the registered setpoint once it holds the start speed
      while (torque_off !== 1'b1 && n < 400) begin
        @(posedge sys_clk);
        if (i == 2 && n > 0) speed <= setp;
        #1;
        n++;
      end
      if (i == 1) chk("deviation abort", 1, n >= 15 && n <= 22);
      if (i == 2) chk("standstill stop", 1, n > 40 && setp <= 16'h0010);
      chk("ramp ends", 1, {torque_off, ramp_act} === 2'h2);
    end
    do_reset;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("input seen", 2'h1, fdi_safe);
    @(posedge sys_clk);
    disc <= 2'h1;
    @(posedge sys_clk);
    disc <= 2'h0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("disc held", 2'h0, fdi_safe);
    fsack(3'h1);
    chk("disc cleared", 2'h1, fdi_safe);
    for (i = 3; i < 5; i++) begin
      fire(i);
      @(posedge sys_clk);
      #1;
      chk("general set", 2'h2, {gen_flt, torque_off});
      apb(1'b1, OFF_ACK, 32'h0000_0002);
      chk("general clear", 0, gen_flt);
    end
    fire(0);
    do_reset;
    #1;
    chk("power ack", 0, {torque_off, int_ev});
    test_done();
  end
endmodule
`default_nettype wire
